// File: logic/vocs_code_select.sv
// Per-pixel output code selector for the 525-line blanking interval
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "vocs_defines.svh"
module vocs_code_select (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [9:0] in_line,
   input  wire logic [9:0] in_pixel,
   input  wire logic [7:0] in_raw,
   input  wire logic [7:0] in_luma,
   input  wire logic [7:0] in_luma_setup,
   input  wire logic [7:0] in_chroma,
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic      [7:0] out_luma,
   output logic      [7:0] out_chroma,
   output logic            out_setup
);
   logic [7:0]            blanking_r;
   logic [7:0]            setup_r;
   logic [7:0]            reg_rdata_r;
   logic                  stage_valid_r;
   logic [16:0]           stage_word_r;
   vocs_pkg::vocs_mode_type last_mode_r;
   logic                  last_setup_r;
   wire                   blanking_decode_enable;
   wire                   half_line_setup_enable;
   wire  [9:0]            blanking_length_lines;
   wire                   setup_enable;
   wire  [9:0]            half_line;
   wire                   first_half;
   wire                   second_half;
   wire                   in_always_black;
   wire                   in_f1_blank;
   wire                   in_f1_active;
   wire                   in_mid_black;
   wire                   in_f2_blank;
   wire                   in_half_line;
   vocs_pkg::vocs_mode_type mode;
   wire                   apply_setup;
   wire  [7:0]            sel_luma;
   wire  [7:0]            sel_chroma;
   wire                   stage_load;
   wire                   fifo_wr_ready;
   wire  [16:0]           fifo_rd_data;

   // Control fields
   assign blanking_decode_enable = blanking_r[`VOCS_BLK_DECODE_BIT];
   assign half_line_setup_enable = blanking_r[`VOCS_BLK_HALF_BIT];
   assign blanking_length_lines  =
      {5'h00, blanking_r[`VOCS_BLK_LEN_MSB:`VOCS_BLK_LEN_LSB]};
   assign setup_enable           = setup_r[`VOCS_SETUP_BIT];

   // Raster landmarks
   assign half_line   = `VOCS_LINE_FIELD1_LAST + blanking_length_lines;
   assign first_half  = (in_pixel <= `VOCS_PIXEL_HALF_LAST);
   assign second_half = (in_pixel >= `VOCS_PIXEL_HALF_FIRST);

   // Region decode, first match in priority order below
   assign in_always_black = (in_line <= `VOCS_LINE_ALWAYS_BLACK_END); // see [RULE9]
   assign in_f1_blank     = (in_line <= blanking_length_lines); // see [RULE9]
   assign in_f1_active    = (in_line < `VOCS_LINE_FIELD1_LAST) ||
                            ((in_line == `VOCS_LINE_FIELD1_LAST) && first_half); // see [RULE6]
   assign in_mid_black    = (in_line <= `VOCS_LINE_FIELD1_LAST) ||
                            (in_line < `VOCS_LINE_FIELD2_MID) ||
                            ((in_line == `VOCS_LINE_FIELD2_MID) && first_half); // see [RULE4] [RULE5]
   assign in_f2_blank     = (in_line < half_line) ||
                            ((in_line == half_line) && first_half); // see [RULE7]
   assign in_half_line    = (in_line == half_line) && second_half; // see [RULE8]

   // Output code choice
   assign mode =
      in_always_black ? vocs_pkg::VOCS_MODE_BLACK :               // see [RULE9]
      in_f1_blank     ? (blanking_decode_enable ? vocs_pkg::VOCS_MODE_RAW
                                                : vocs_pkg::VOCS_MODE_BLACK) : // see [RULE1] [RULE2]
      in_f1_active    ? vocs_pkg::VOCS_MODE_DECODE :
      in_mid_black    ? vocs_pkg::VOCS_MODE_BLACK :               // see [RULE4] [RULE5]
      in_f2_blank     ? (blanking_decode_enable ? vocs_pkg::VOCS_MODE_RAW
                                                : vocs_pkg::VOCS_MODE_BLACK) : // see [RULE7]
      vocs_pkg::VOCS_MODE_DECODE;

   // Setup only in decoded regions; half line needs both bits
   assign apply_setup = (mode == vocs_pkg::VOCS_MODE_DECODE) && setup_enable &&
                        (!in_half_line || half_line_setup_enable); // see [RULE3] [RULE8] [RULE10]

   // Sample selection
   assign sel_luma =
      (mode == vocs_pkg::VOCS_MODE_BLACK) ? `VOCS_BLACK_LUMA :    // see [RULE1]
      (mode == vocs_pkg::VOCS_MODE_RAW)   ? in_raw :               // see [RULE2]
      apply_setup                         ? in_luma_setup : in_luma; // see [RULE6]
   assign sel_chroma = (mode == vocs_pkg::VOCS_MODE_DECODE) ? in_chroma
                                                            : `VOCS_NEUTRAL_CHROMA;

   // Stage advances when empty or when the FIFO takes its word
   assign stage_load = !stage_valid_r || fifo_wr_ready;
   assign in_ready   = stage_load;

   // Output stage register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stage_valid_r <= 1'b0;
         stage_word_r  <= '0;
         last_mode_r   <= vocs_pkg::VOCS_MODE_BLACK;
         last_setup_r  <= 1'b0;
      end else if (stage_load) begin
         stage_valid_r <= in_valid;
         if (in_valid) begin
            stage_word_r <= {apply_setup, sel_luma, sel_chroma};
            last_mode_r  <= mode;
            last_setup_r <= apply_setup;
         end
      end
   end

   // Buffer toward the video output
   vocs_fifo #(
      .WIDTH (`VOCS_WORD_WIDTH),
      .DEPTH (`VOCS_FIFO_DEPTH)
   ) u_fifo (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_valid (stage_valid_r),
      .wr_ready (fifo_wr_ready),
      .wr_data  (stage_word_r),
      .rd_valid (out_valid),
      .rd_ready (out_ready),
      .rd_data  (fifo_rd_data)
   );

   assign out_setup  = fifo_rd_data[16];
   assign out_luma   = fifo_rd_data[15:8];
   assign out_chroma = fifo_rd_data[7:0];

   // Register writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         blanking_r <= `VOCS_BLK_RESET;
         setup_r    <= `VOCS_SETUP_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `VOCS_ADDR_BLANKING) begin
            blanking_r <= reg_wdata;
         end
         if (reg_addr == `VOCS_ADDR_SETUP) begin
            setup_r <= {7'h00, reg_wdata[`VOCS_SETUP_BIT]};
         end
      end
   end

   // Register reads, data valid only the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `VOCS_ADDR_BLANKING: reg_rdata_r <= blanking_r;
            `VOCS_ADDR_SETUP:    reg_rdata_r <= setup_r;
            `VOCS_ADDR_STATUS:   reg_rdata_r <= {4'h0, last_setup_r, last_mode_r};
            default:             reg_rdata_r <= 8'h00;
         endcase
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end
   assign reg_rdata = reg_rdata_r;
endmodule // vocs_code_select

// File: logic/vocs_defines.svh
// Constants for the blanking-interval output code selector
// Operation
// [RULE1] Blanking period outputs black code by default
// [RULE2] Decode bit sends raw input as luma
// [RULE3] Setup bit ignored inside blanking period
// [RULE4] Line 263 from pixel 430 outputs black
// [RULE5] Line 264 to 272 pixel 429 black
// [RULE6] First field active lines decode, setup-bit controlled
// [RULE7] Second field blanking tail: black or raw
// [RULE8] Half line decodes, setup needs both bits
// [RULE9] Lines 1-9 black; field-one blanking follows decode
// [RULE10] Half-line setup only on second-field first line
`ifndef VOCS_DEFINES_SVH
`define VOCS_DEFINES_SVH

// Video levels
`define VOCS_BLACK_LUMA      8'h10
`define VOCS_NEUTRAL_CHROMA  8'h80

// Line and pixel landmarks of the 525-line raster
`define VOCS_LINE_ALWAYS_BLACK_END 10'h009
`define VOCS_LINE_FIELD1_LAST      10'h107
`define VOCS_LINE_FIELD2_FIRST     10'h108
`define VOCS_LINE_FIELD2_MID       10'h110
`define VOCS_PIXEL_HALF_LAST       10'h1AD
`define VOCS_PIXEL_HALF_FIRST      10'h1AE

// Register offsets
`define VOCS_ADDR_BLANKING   4'h0
`define VOCS_ADDR_SETUP      4'h1
`define VOCS_ADDR_STATUS     4'h2

// Blanking and setup register fields
`define VOCS_BLK_DECODE_BIT  7
`define VOCS_BLK_HALF_BIT    5
`define VOCS_BLK_LEN_MSB     4
`define VOCS_BLK_LEN_LSB     0
`define VOCS_BLK_RESET       8'h14
`define VOCS_SETUP_BIT       0
`define VOCS_SETUP_RESET     8'h00

// FIFO shape
`define VOCS_FIFO_DEPTH      8
`define VOCS_WORD_WIDTH      17

`endif

// File: logic/vocs_pkg.sv
// Types shared by the blanking-interval output code selector
package vocs_pkg;

   // One-hot output code choice
   typedef enum logic [2:0] {
      VOCS_MODE_BLACK  = 3'b001,
      VOCS_MODE_RAW    = 3'b010,
      VOCS_MODE_DECODE = 3'b100
   } vocs_mode_type;

endpackage

// File: logic/vocs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module vocs_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic                  rd_valid,
   input  wire logic             rd_ready,
   output logic      [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push;
   wire              pop;

   // Handshake and honest full/empty
   assign wr_ready = (count_r != (AW+1)'(DEPTH));
   assign rd_valid = (count_r != '0);
   assign push     = wr_valid && wr_ready;
   assign pop      = rd_valid && rd_ready;
   assign rd_data  = mem_r[rd_ptr_r];

   // Storage array
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= wr_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // vocs_fifo

// File: bench/vocs_checker.sv
// Port-level assertions for the output code selector
`timescale 1ns/1ps
module vocs_checker (
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       in_valid,
   input wire logic       in_ready,
   input wire logic       out_valid,
   input wire logic       out_ready,
   input wire logic [7:0] out_luma,
   input wire logic [7:0] out_chroma,
   input wire logic       out_setup
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Stream steps
   sequence stalled; out_valid && !out_ready; endsequence
   sequence take_empty; in_valid && in_ready && !out_valid; endsequence
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data leak");
   a_write_quiet: assert property (reg_wr |=> reg_rdata == 8'h00) else $error("write drove data");
   a_status_code: assert property (reg_rd && reg_addr == 4'h2 |=>
      $onehot(reg_rdata[2:0]) && reg_rdata[7:4] == 4'h0) else $error("bad status");
   a_setup_decode: assert property (reg_rd && reg_addr == 4'h2 |=>
      !reg_rdata[3] || reg_rdata[2]) else $error("setup outside decode");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h2 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_hold_luma: assert property (stalled |=> out_valid && $stable(out_luma))
      else $error("luma moved while stalled");
   a_hold_rest: assert property (stalled |=> $stable({out_chroma, out_setup}))
      else $error("chroma moved while stalled");
   a_fill_latency: assert property (take_empty |-> ##2 out_valid) else $error("late word");
   a_empty_ready: assert property (!out_valid |-> in_ready) else $error("refused when empty");
endmodule // vocs_checker

// File: bench/vocs_sink.sv
// Downstream video receiver model with a stall pattern
`timescale 1ns/1ps
module vocs_sink (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic hold_off,
   output logic      out_ready
);
   logic [1:0] beat_r;
   // Refuses one beat in four, and every beat while held off
   always_ff @(posedge core_clk) begin
      beat_r <= sys_rst ? 2'h0 : beat_r + 2'h1;
      out_ready <= !sys_rst && !hold_off && beat_r != 2'h3;
   end
endmodule // vocs_sink

// File: bench/tb_top.sv
// Self-checking bench for the output code selector
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, in_valid = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, out_luma, out_chroma;
   logic [9:0] in_line = 10'h001, in_pixel = 10'h001;
   logic [7:0] in_raw = 8'hA5, in_luma = 8'h5A, in_luma_setup = 8'h66, in_chroma = 8'h33;
   logic       in_ready, out_valid, out_ready, out_setup, hold_off = 1'b1;
   logic       dec, half, su;
   int         nlen, k, c, p, n_sent = 0, refused_at = 0, n_fail = 0, n_compared = 0;
   logic [16:0] exp_q[$];
   int ln_t[16] = '{5, 20, 21, 263, 263, 263, 264, 272, 272, 275, 275, 282, 283, 283, 284, 525};
   int px_t[16] = '{1, 858, 1, 429, 430, 858, 1, 429, 430, 429, 430, 858, 429, 430, 1, 858};
   always #2 core_clk = ~core_clk;
   vocs_code_select DUT (
      .core_clk      (core_clk),
      .sys_rst       (sys_rst),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .in_valid      (in_valid),
      .in_ready      (in_ready),
      .in_line       (in_line),
      .in_pixel      (in_pixel),
      .in_raw        (in_raw),
      .in_luma       (in_luma),
      .in_luma_setup (in_luma_setup),
      .in_chroma     (in_chroma),
      .out_valid     (out_valid),
      .out_ready     (out_ready),
      .out_luma      (out_luma),
      .out_chroma    (out_chroma),
      .out_setup     (out_setup)
   );
   vocs_sink sink (.core_clk(core_clk), .sys_rst(sys_rst), .hold_off(hold_off),
      .out_ready(out_ready));
   task automatic check(input string what, input logic [16:0] e, input logic [16:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk) reg_wr <= 1'b0;
      // One idle edge so the next call never re-drives the strobe in this step
      @(posedge core_clk);
   endtask
   task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk) reg_rd <= 1'b0;
      #1 check("register", {9'h000, e}, {9'h000, reg_rdata});
      @(posedge core_clk);
   endtask
   // Expected word from line, pixel and settings
   function automatic logic [16:0] want(input int ln, input int px);
      logic [16:0] blk, vb;
      blk = {8'h10, 8'h80, 1'b0};
      vb = dec ? {8'hA5, 8'h80, 1'b0} : blk;
      if (ln <= 9) return blk;
      if (ln <= nlen) return vb;
      if (ln < 263 || (ln == 263 && px <= 429)) return {su ? 8'h66 : 8'h5A, 8'h33, su};
      if (ln <= 271 || (ln == 272 && px <= 429)) return blk;
      if (ln < 263 + nlen || (ln == 263 + nlen && px <= 429)) return vb;
      if (ln == 263 + nlen) return {su && half ? 8'h66 : 8'h5A, 8'h33, su && half};
      return {su ? 8'h66 : 8'h5A, 8'h33, su};
   endfunction
   task automatic send(input int ln, input int px);
      in_line <= ln[9:0];
      in_pixel <= px[9:0];
      in_valid <= 1'b1;
      exp_q.push_back(want(ln, px));
      n_sent++;
      @(negedge core_clk);
      for (k = 0; !in_ready; k++) begin
         if (refused_at == 0) refused_at = n_sent;
         if (k == 20) hold_off <= 1'b0;
         if (k == 300) n_fail++;
         if (k == 300) report_and_stop();
         @(negedge core_clk);
      end
      @(posedge core_clk);
   endtask
   // Output words compared in order as the receiver takes them
   always @(posedge core_clk) begin
      if (!sys_rst && out_valid && out_ready) begin
         // A word with nothing expected is a pairing fault
         if (exp_q.size() == 0) check("word count", 17'h00000, 17'h00001);
         else check("word", exp_q.pop_front(), {out_luma, out_chroma, out_setup});
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      reg_read(4'h0, 8'h14);
      reg_read(4'h1, 8'h00);
      reg_read(4'h2, 8'h01);
      reg_write(4'h3, 8'hFF);
      reg_read(4'h3, 8'h00);
      for (c = 0; c < 8; c++) begin
         {dec, half, su} = c[2:0];
         nlen = dec ? 12 : 20;
         reg_write(4'h0, {dec, 1'b1, half, nlen[4:0]});
         reg_write(4'h1, {7'h00, su});
         reg_read(4'h0, {dec, 1'b1, half, nlen[4:0]});
         for (p = 0; p < 16; p++) send(ln_t[p], px_t[p]);
         // No stray samples while the settings change
         in_valid <= 1'b0;
      end
      check("first refusal", 17'd10, refused_at[16:0]);
      for (k = 0; k < 2000 && exp_q.size() != 0; k++) @(posedge core_clk);
      check("left over", 17'h0, 17'(exp_q.size()));
      reg_read(4'h2, 8'h0C);
      report_and_stop();
   end
endmodule // tb_top
bind vocs_code_select vocs_checker chk (
   .core_clk   (core_clk),
   .sys_rst    (sys_rst),
   .reg_addr   (reg_addr),
   .reg_wr     (reg_wr),
   .reg_rd     (reg_rd),
   .reg_rdata  (reg_rdata),
   .in_valid   (in_valid),
   .in_ready   (in_ready),
   .out_valid  (out_valid),
   .out_ready  (out_ready),
   .out_luma   (out_luma),
   .out_chroma (out_chroma),
   .out_setup  (out_setup)
);
